// ---- pkg/nsm_defines.svh ----
/*
 * Offsets, field positions, reset values and limits of the slave mailbox.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef NSM_DEFINES_SVH
`define NSM_DEFINES_SVH

// ****************************************************************
// Register port map (word addresses below 10'h200 reach the mailbox store)
// ****************************************************************
`define NSM_REG_OWN       10'h200
`define NSM_REG_SEND_LOC  10'h201
`define NSM_REG_RECV_LOC  10'h202
`define NSM_REG_RHS_LOC   10'h203
`define NSM_REG_SHS_LOC   10'h204
`define NSM_REG_PGM       10'h205
`define NSM_REG_SHS       10'h206
`define NSM_REG_RHS       10'h207
`define NSM_REG_STATUS    10'h208
`define NSM_REG_MASK      10'h209
`define NSM_REG_RX_AREA   10'h20A

// ****************************************************************
// Handshake byte fields
// ****************************************************************
`define NSM_SHS_BUSY      7
`define NSM_SHS_EXPRESS   4
`define NSM_SHS_ERR       0
`define NSM_RHS_FREE      7
`define NSM_RHS_EXPRESS   2
`define NSM_RHS_RUN       1
`define NSM_RHS_FAIL      0

// ****************************************************************
// Status and mask bits
// ****************************************************************
`define NSM_EV_TX_DONE    0
`define NSM_EV_TX_ERR     1
`define NSM_EV_RX_FRAME   2
`define NSM_EV_RX_DROP    3
`define NSM_EV_W          4

// ****************************************************************
// Limits and layout
// ****************************************************************
`define NSM_MAX_PAYLOAD   7'h40
`define NSM_MIN_BLOCK     8'h02
`define NSM_FLAG_LIMIT    8'h7F
`define NSM_STATION_MASTER 5'h00
`define NSM_STATION_ALL   5'h1F
`define NSM_FLAG_BASE     10'h200
`define NSM_HDR_BYTES     10'h002

// ****************************************************************
// Reset values
// ****************************************************************
`define NSM_RST_OWN       5'h01
`define NSM_RST_PGM       5'h01
`define NSM_RST_SEND_LOC  17'h00200
`define NSM_RST_RECV_LOC  17'h0020A
`define NSM_RST_RHS_LOC   17'h10002
`define NSM_RST_SHS_LOC   17'h10000
`define NSM_RST_RX_AREA   7'h40

`endif

// ---- pkg/nsm_pkg.sv ----
/*
 * Types shared by the slave mailbox design.
 * Assumes the defines header sits on the include path.
 */
package nsm_pkg;
  `include "nsm_defines.svh"

  // Location of a mailbox or handshake byte: flag byte z or block x word y
  typedef struct packed {
    logic       in_flags;
    logic [7:0] block;
    logic [7:0] index;
  } nsm_loc_t;

  // Frame header handed to the network engine
  typedef struct packed {
    logic [4:0] dest;
    logic       to_master;
    logic       to_all;
    logic [6:0] len;
    logic       express;
  } nsm_tx_hdr_t;

  // Frame header delivered by the network engine
  typedef struct packed {
    logic [4:0] src;
    logic [4:0] dest;
    logic       express;
  } nsm_rx_hdr_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_TX_LEN  = 3'b001,
    ST_TX_DST  = 3'b010,
    ST_TX_DATA = 3'b011,
    ST_TX_WAIT = 3'b100
  } nsm_tx_state_t;
endpackage

// ---- design/nsm_mbox_mem.sv ----
/*
 * Mailbox store: 512 words of 16 bits, left byte in bits 15:8.
 * Port A serves software, port B reads for the sender, port C writes for
 * the receiver. Assumes the caller keeps A and C off the same word at once.
 */
`timescale 1ns/1ns
module nsm_mbox_mem (
  input  wire logic        core_clk_i,
  input  wire logic [8:0]  a_addr_i,
  input  wire logic        a_we_i,
  input  wire logic        a_re_i,
  input  wire logic [15:0] a_wdata_i,
  input  wire logic        a_bypass_i,
  input  wire logic [31:0] a_bypass_data_i,
  output logic      [31:0] a_rdata_o,
  input  wire logic [8:0]  b_addr_i,
  input  wire logic        b_re_i,
  output logic      [15:0] b_rdata_o,
  input  wire logic [8:0]  c_addr_i,
  input  wire logic [1:0]  c_be_i,
  input  wire logic [15:0] c_wdata_i
);
  logic [15:0] mem [0:511];

  // The bus read register also carries register reads, so the bus output
  // stays a single flop whatever was addressed
  always_ff @(posedge core_clk_i) begin
    if (a_bypass_i) begin
      a_rdata_o <= a_bypass_data_i;
    end else if (a_re_i) begin
      a_rdata_o <= {16'h0000, mem[a_addr_i]};
    end
    if (b_re_i) begin
      b_rdata_o <= mem[b_addr_i];
    end
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    if (c_be_i[1]) begin
      mem[c_addr_i][15:8] <= c_wdata_i[15:8];
    end
    if (c_be_i[0]) begin
      mem[c_addr_i][7:0] <= c_wdata_i[7:0];
    end
  end
endmodule

// ---- design/nsm_mailbox.sv ----
/*
 * Slave-side mailbox: parameter set, send and receive mailboxes in a shared
 * store, send and receive handshake bytes, interrupt status.
 * Assumes a network engine that frames bytes, reports send completion and
 * delivers received frames as header, bytes and end pulses.
 */
`timescale 1ns/1ns
`include "nsm_defines.svh"

module nsm_mailbox (
  input  wire logic                core_clk_i,
  input  wire logic                nrst_i,
  input  wire logic [9:0]          addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [31:0]         rdata_o,
  output nsm_pkg::nsm_tx_hdr_t     tx_hdr_o,
  output logic                     tx_start_o,
  output logic                     tx_prio_o,
  output logic                     tx_valid_o,
  output logic      [7:0]          tx_data_o,
  output logic                     tx_last_o,
  input  wire logic                tx_ready_i,
  input  wire logic                tx_done_i,
  input  wire logic                tx_err_i,
  input  wire logic                rx_sof_i,
  input  wire nsm_pkg::nsm_rx_hdr_t rx_hdr_i,
  input  wire logic                rx_valid_i,
  input  wire logic [7:0]          rx_data_i,
  input  wire logic                rx_eof_i,
  input  wire logic                slave_failed_i,
  input  wire logic                bus_run_i,
  output logic                     irq_o,
  output logic      [4:0]          own_station_o,
  output logic      [4:0]          pgm_station_o
);
  import nsm_pkg::*;

  // ****************************************************************
  // Parameter set and control registers
  // ****************************************************************
  nsm_loc_t    send_loc_q, recv_loc_q, rhs_loc_q, shs_loc_q;
  logic [6:0]  rx_area_q;
  logic        shs_busy_q, shs_expr_q, shs_err_q;
  logic        rhs_free_q, rhs_expr_q, rhs_run_q, rhs_fail_q;
  logic [`NSM_EV_W-1:0] status_q, mask_q, ev_set;

  wire is_mem   = ~addr_i[9];
  wire wr_reg   = wr_i & ~is_mem;
  wire wr_own   = wr_reg & (addr_i == `NSM_REG_OWN);
  wire wr_sloc  = wr_reg & (addr_i == `NSM_REG_SEND_LOC);
  wire wr_rloc  = wr_reg & (addr_i == `NSM_REG_RECV_LOC);
  wire wr_rhl   = wr_reg & (addr_i == `NSM_REG_RHS_LOC);
  wire wr_shl   = wr_reg & (addr_i == `NSM_REG_SHS_LOC);
  wire wr_pgm   = wr_reg & (addr_i == `NSM_REG_PGM);
  wire wr_shs   = wr_reg & (addr_i == `NSM_REG_SHS);
  wire wr_rhs   = wr_reg & (addr_i == `NSM_REG_RHS);
  wire wr_stat  = wr_reg & (addr_i == `NSM_REG_STATUS);
  wire wr_mask  = wr_reg & (addr_i == `NSM_REG_MASK);
  wire wr_area  = wr_reg & (addr_i == `NSM_REG_RX_AREA);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      own_station_o <= `NSM_RST_OWN;
      pgm_station_o <= `NSM_RST_PGM;
      send_loc_q    <= `NSM_RST_SEND_LOC;
      recv_loc_q    <= `NSM_RST_RECV_LOC;
      rhs_loc_q     <= `NSM_RST_RHS_LOC;
      shs_loc_q     <= `NSM_RST_SHS_LOC;
      rx_area_q     <= `NSM_RST_RX_AREA;
      mask_q        <= '0;
    end else begin
      if (wr_own)  own_station_o <= wdata_i[4:0];
      if (wr_pgm)  pgm_station_o <= wdata_i[4:0];
      if (wr_sloc) send_loc_q    <= wdata_i[16:0];
      if (wr_rloc) recv_loc_q    <= wdata_i[16:0];
      if (wr_rhl)  rhs_loc_q     <= wdata_i[16:0];
      if (wr_shl)  shs_loc_q     <= wdata_i[16:0];
      if (wr_area) rx_area_q     <= (wdata_i[6:0] > `NSM_MAX_PAYLOAD) ?
                                    `NSM_MAX_PAYLOAD : wdata_i[6:0];
      if (wr_mask) mask_q        <= wdata_i[`NSM_EV_W-1:0];
    end
  end

  // ****************************************************************
  // Location checks and byte addressing
  // ****************************************************************
  // All block numbers share one backing store; a block number only has to
  // be legal. Flag byte z sits at byte NSM_FLAG_BASE + z.
  function automatic logic loc_ok(input nsm_loc_t l);
    loc_ok = l.in_flags ? (l.index <= `NSM_FLAG_LIMIT)
                        : (l.block >= `NSM_MIN_BLOCK);
  endfunction

  function automatic logic [9:0] loc_base(input nsm_loc_t l);
    loc_base = l.in_flags ? (`NSM_FLAG_BASE + {2'b00, l.index})
                          : {1'b0, l.index, 1'b0};
  endfunction

  wire [9:0] send_base = loc_base(send_loc_q);
  wire [9:0] recv_base = loc_base(recv_loc_q);
  wire       send_ok   = loc_ok(send_loc_q) & loc_ok(shs_loc_q);
  wire       recv_ok   = loc_ok(recv_loc_q) & loc_ok(rhs_loc_q);

  // ****************************************************************
  // Send sequencer
  // ****************************************************************
  nsm_tx_state_t state_q;
  logic [9:0]  tx_ptr_q;
  logic [6:0]  tx_len_q, tx_cnt_q;
  logic        b_pend_q, b_lane_q;
  logic [15:0] b_rdata;
  logic        tx_valid_q;

  wire [7:0] b_byte    = b_lane_q ? b_rdata[7:0] : b_rdata[15:8];
  wire       tx_begin  = (state_q == ST_IDLE) & shs_busy_q & send_ok;
  wire       tx_bad    = (state_q == ST_IDLE) & shs_busy_q & ~send_ok;
  wire       tx_take   = (state_q == ST_TX_DATA) & tx_valid_q & tx_ready_i;
  wire       tx_final  = tx_take & (tx_cnt_q + 7'h01 == tx_len_q);
  wire [6:0] len_clip  = (b_byte[6:0] > `NSM_MAX_PAYLOAD) | b_byte[7] ?
                         `NSM_MAX_PAYLOAD : b_byte[6:0];
  wire       b_re      = tx_begin | (state_q == ST_TX_LEN) |
                         ((state_q == ST_TX_DST) & (tx_len_q != 7'h00)) |
                         (tx_take & ~tx_final);
  wire [9:0] b_addr    = tx_begin ? send_base : tx_ptr_q;
  wire       tx_finish = ((state_q == ST_TX_WAIT) & tx_done_i) | tx_bad;
  wire       tx_fail   = ((state_q == ST_TX_WAIT) & tx_done_i & tx_err_i) | tx_bad;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q    <= ST_IDLE;
      tx_ptr_q   <= '0;
      tx_len_q   <= '0;
      tx_cnt_q   <= '0;
      b_pend_q   <= 1'b0;
      b_lane_q   <= 1'b0;
      tx_hdr_o   <= '0;
      tx_start_o <= 1'b0;
      tx_prio_o  <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_o  <= '0;
      tx_last_o  <= 1'b0;
    end else begin
      b_pend_q   <= b_re;
      b_lane_q   <= b_addr[0];
      tx_start_o <= 1'b0;
      if (b_re) tx_ptr_q <= b_addr + 10'h001;
      case (state_q)
        ST_IDLE: begin
          if (tx_begin) state_q <= ST_TX_LEN;
        end
        ST_TX_LEN: begin
          tx_len_q <= len_clip;
          state_q  <= ST_TX_DST;
        end
        ST_TX_DST: begin
          tx_hdr_o.dest      <= b_byte[4:0];
          tx_hdr_o.to_master <= (b_byte[4:0] == `NSM_STATION_MASTER);
          tx_hdr_o.to_all    <= (b_byte[4:0] == `NSM_STATION_ALL);
          tx_hdr_o.len       <= tx_len_q;
          tx_hdr_o.express   <= shs_expr_q;
          tx_prio_o          <= shs_expr_q;
          tx_start_o         <= 1'b1;
          tx_cnt_q           <= '0;
          state_q            <= (tx_len_q == 7'h00) ? ST_TX_WAIT : ST_TX_DATA;
        end
        ST_TX_DATA: begin
          if (b_pend_q) begin
            tx_valid_q <= 1'b1;
            tx_data_o  <= b_byte;
            tx_last_o  <= (tx_cnt_q + 7'h01 == tx_len_q);
          end else if (tx_take) begin
            tx_valid_q <= 1'b0;
            tx_last_o  <= 1'b0;
            tx_cnt_q   <= tx_cnt_q + 7'h01;
            if (tx_final) state_q <= ST_TX_WAIT;
          end
        end
        ST_TX_WAIT: begin
          if (tx_done_i) begin
            state_q   <= ST_IDLE;
            tx_prio_o <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign tx_valid_o = tx_valid_q;

  // Send handshake byte: software may only raise busy while it is clear
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shs_busy_q <= 1'b0;
      shs_expr_q <= 1'b0;
      shs_err_q  <= 1'b0;
    end else if (tx_finish) begin
      shs_busy_q <= 1'b0;
      shs_err_q  <= tx_fail;
    end else if (wr_shs & ~shs_busy_q) begin
      shs_busy_q <= wdata_i[`NSM_SHS_BUSY];
      shs_expr_q <= wdata_i[`NSM_SHS_EXPRESS];
      shs_err_q  <= wdata_i[`NSM_SHS_BUSY] ? 1'b0 : wdata_i[`NSM_SHS_ERR];
    end
  end

  // ****************************************************************
  // Receive path
  // ****************************************************************
  logic       rx_on_q;
  logic [6:0] rx_cnt_q;
  logic [1:0] rx_fin_q;
  logic [4:0] rx_src_q;
  logic       rx_expr_q;

  // A frame is only taken into a free, legal mailbox and for this station
  wire rx_for_us  = (rx_hdr_i.dest == own_station_o) |
                    (rx_hdr_i.dest == `NSM_STATION_ALL);
  wire rx_accept  = rx_sof_i & rx_for_us & rhs_free_q & recv_ok & (rx_fin_q == 2'd0);
  wire rx_drop    = rx_sof_i & rx_for_us & ~rx_accept;
  wire rx_store   = rx_on_q & rx_valid_i & (rx_cnt_q < rx_area_q);
  wire rx_count   = rx_on_q & rx_valid_i & (rx_cnt_q < `NSM_MAX_PAYLOAD);
  wire rx_stored  = (rx_fin_q == 2'd2);
  wire [9:0] c_byte = rx_store ? recv_base + `NSM_HDR_BYTES + {3'b000, rx_cnt_q} :
                      (rx_fin_q == 2'd1) ? recv_base : recv_base + 10'h001;
  wire [7:0] c_val  = rx_store ? rx_data_i :
                      (rx_fin_q == 2'd1) ? {1'b0, rx_cnt_q} : {3'b000, rx_src_q};
  wire       c_we   = rx_store | (rx_fin_q != 2'd0);
  wire [1:0] c_be   = c_we ? (c_byte[0] ? 2'b01 : 2'b10) : 2'b00;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_on_q   <= 1'b0;
      rx_cnt_q  <= '0;
      rx_fin_q  <= 2'd0;
      rx_src_q  <= '0;
      rx_expr_q <= 1'b0;
    end else begin
      if (rx_accept) begin
        rx_on_q   <= 1'b1;
        rx_cnt_q  <= '0;
        rx_src_q  <= rx_hdr_i.src;
        rx_expr_q <= rx_hdr_i.express;
      end else if (rx_on_q & rx_eof_i) begin
        rx_on_q  <= 1'b0;
        rx_fin_q <= 2'd1;
      end else if (rx_count) begin
        rx_cnt_q <= rx_cnt_q + 7'h01;
      end
      if (rx_fin_q != 2'd0) rx_fin_q <= rx_fin_q + 2'd1;
      if (rx_stored) rx_fin_q <= 2'd0;
    end
  end

  // Receive handshake byte; the device clear beats a software set
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rhs_free_q <= 1'b1;
      rhs_expr_q <= 1'b0;
      rhs_run_q  <= 1'b0;
      rhs_fail_q <= 1'b0;
    end else begin
      rhs_run_q  <= bus_run_i;
      rhs_fail_q <= slave_failed_i;
      if (rx_stored) begin
        rhs_free_q <= 1'b0;
        rhs_expr_q <= rx_expr_q;
      end else if (wr_rhs & wdata_i[`NSM_RHS_FREE]) begin
        rhs_free_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Interrupt status: write one to clear, a new event wins
  // ****************************************************************
  always_comb begin
    ev_set = '0;
    ev_set[`NSM_EV_TX_DONE]  = tx_finish;
    ev_set[`NSM_EV_TX_ERR]   = tx_fail;
    ev_set[`NSM_EV_RX_FRAME] = rx_stored;
    ev_set[`NSM_EV_RX_DROP]  = rx_drop;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_q <= '0;
      irq_o    <= 1'b0;
    end else begin
      status_q <= (status_q & ~(wr_stat ? wdata_i[`NSM_EV_W-1:0] : '0)) | ev_set;
      irq_o    <= |(((status_q & ~(wr_stat ? wdata_i[`NSM_EV_W-1:0] : '0)) | ev_set)
                    & mask_q);
    end
  end

  // ****************************************************************
  // Register read mux and mailbox store
  // ****************************************************************
  wire [7:0] shs_byte = {shs_busy_q, 2'b00, shs_expr_q, 3'b000, shs_err_q};
  wire [7:0] rhs_byte = {rhs_free_q, 4'b0000, rhs_expr_q, rhs_run_q, rhs_fail_q};
  logic [31:0] reg_rdata;

  always_comb begin
    case (addr_i)
      `NSM_REG_OWN:      reg_rdata = {27'h0, own_station_o};
      `NSM_REG_SEND_LOC: reg_rdata = {15'h0, send_loc_q};
      `NSM_REG_RECV_LOC: reg_rdata = {15'h0, recv_loc_q};
      `NSM_REG_RHS_LOC:  reg_rdata = {15'h0, rhs_loc_q};
      `NSM_REG_SHS_LOC:  reg_rdata = {15'h0, shs_loc_q};
      `NSM_REG_PGM:      reg_rdata = {27'h0, pgm_station_o};
      `NSM_REG_SHS:      reg_rdata = {24'h0, shs_byte};
      `NSM_REG_RHS:      reg_rdata = {24'h0, rhs_byte};
      `NSM_REG_STATUS:   reg_rdata = {28'h0, status_q};
      `NSM_REG_MASK:     reg_rdata = {28'h0, mask_q};
      `NSM_REG_RX_AREA:  reg_rdata = {25'h0, rx_area_q};
      default:           reg_rdata = 32'h0000_0000;
    endcase
  end

  nsm_mbox_mem u_mem (
    .core_clk_i      (core_clk_i),
    .a_addr_i        (addr_i[8:0]),
    .a_we_i          (wr_i & is_mem),
    .a_re_i          (rd_i & is_mem),
    .a_wdata_i       (wdata_i[15:0]),
    .a_bypass_i      (rd_i & ~is_mem),
    .a_bypass_data_i (reg_rdata),
    .a_rdata_o       (rdata_o),
    .b_addr_i        (b_addr[9:1]),
    .b_re_i          (b_re),
    .b_rdata_o       (b_rdata),
    .c_addr_i        (c_byte[9:1]),
    .c_be_i          (c_be),
    .c_wdata_i       ({c_val, c_val})
  );
endmodule

// ---- test/nsm_mailbox_asserts.sv ----
/* Port checks of the slave mailbox send stream and parameter outputs.
   Bound to nsm_mailbox and sees only its ports. */
`timescale 1ns/1ns
module nsm_mailbox_asserts (
  input wire logic                 core_clk_i,
  input wire logic                 nrst_i,
  input wire logic [9:0]           addr_i,
  input wire logic                 wr_i,
  input wire nsm_pkg::nsm_tx_hdr_t tx_hdr_o,
  input wire logic                 tx_start_o,
  input wire logic                 tx_prio_o,
  input wire logic                 tx_valid_o,
  input wire logic [7:0]           tx_data_o,
  input wire logic                 tx_last_o,
  input wire logic                 tx_ready_i,
  input wire logic                 tx_done_i,
  input wire logic [4:0]           own_station_o,
  input wire logic [4:0]           pgm_station_o
);
  import nsm_pkg::*;
  // ****************************************
  // Send stream and parameter checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic fly_q;
  // A frame is in flight from its start pulse until the engine reports done
  always_ff @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i) fly_q <= 1'b0;
    else if (tx_start_o) fly_q <= 1'b1;
    else if (tx_done_i) fly_q <= 1'b0;
  chk_dest_master: assert property (
    tx_start_o |-> tx_hdr_o.to_master == (tx_hdr_o.dest == 5'h00)) else $error("master flag");
  chk_dest_all: assert property (
    tx_start_o |-> tx_hdr_o.to_all == (tx_hdr_o.dest == 5'h1F)) else $error("broadcast flag");
  chk_len_clip: assert property (
    tx_start_o |-> tx_hdr_o.len <= 7'h40) else $error("length above 64");
  chk_one_frame: assert property (
    tx_start_o |-> !fly_q) else $error("start while busy");
  chk_first_byte: assert property (
    tx_start_o && tx_hdr_o.len != 7'h00 |=> tx_valid_o) else $error("no first byte");
  chk_byte_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("byte dropped");
  chk_byte_gap: assert property (
    tx_valid_o && tx_ready_i && !tx_last_o |=> !tx_valid_o ##1 tx_valid_o)
    else $error("next byte late");
  chk_prio_exp: assert property (
    tx_start_o |=> tx_prio_o == tx_hdr_o.express) else $error("priority wrong");
  chk_prio_drop: assert property (
    tx_done_i |=> !tx_prio_o) else $error("priority stuck");
  chk_own_stable: assert property (
    !(wr_i && addr_i == 10'h200) |=> $stable(own_station_o)) else $error("station moved");
  chk_pgm_stable: assert property (
    !(wr_i && addr_i == 10'h205) |=> $stable(pgm_station_o)) else $error("pgm moved");
endmodule

bind nsm_mailbox nsm_mailbox_asserts u_nsm_mailbox_asserts (
  .core_clk_i, .nrst_i, .addr_i, .wr_i, .tx_hdr_o, .tx_start_o, .tx_prio_o,
  .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .tx_done_i,
  .own_station_o, .pgm_station_o
);

// ---- test/nsm_net_model.sv ----
/* Network engine stand-in: takes send bytes, stalling on request, answers
   with a done pulse and delivers receive frames from its task.
   Assumes the mailbox shares its clock. */
`timescale 1ns/1ns
module nsm_net_model (
  input  wire logic                 core_clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 slow_i,
  input  wire logic                 err_i,
  input  wire logic                 tx_start_i,
  input  wire nsm_pkg::nsm_tx_hdr_t tx_hdr_i,
  input  wire logic                 tx_valid_i,
  input  wire logic [7:0]           tx_data_i,
  input  wire logic                 tx_last_i,
  output logic                      tx_ready_o,
  output logic                      tx_done_o,
  output logic                      tx_err_o,
  output logic                      rx_sof_o,
  output nsm_pkg::nsm_rx_hdr_t      rx_hdr_o,
  output logic                      rx_valid_o,
  output logic [7:0]                rx_data_o,
  output logic                      rx_eof_o
);
  import nsm_pkg::*;
  // ****************************************
  // Send side
  // ****************************************
  logic [7:0]  got [0:63];
  int          n_got;
  int          wait_n;
  nsm_tx_hdr_t hdr;
  initial begin
    {rx_sof_o, rx_valid_o, rx_eof_o} = 3'b000;
    rx_hdr_o = '0;
    rx_data_o = 8'hA5;
  end
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {tx_ready_o, tx_done_o, tx_err_o} <= 3'b000;
      n_got <= 0;
      wait_n <= 0;
    end else begin
      tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
      tx_done_o <= (wait_n == 1);
      // Error line is junk outside the done pulse
      tx_err_o <= (wait_n == 1) ? err_i : ~tx_err_o;
      if (wait_n > 0) wait_n <= wait_n - 1;
      if (tx_start_i) begin
        hdr <= tx_hdr_i;
        n_got <= 0;
        if (tx_hdr_i.len == 7'h00) wait_n <= 3;
      end
      if (tx_valid_i && tx_ready_o) begin
        got[n_got] <= tx_data_i;
        n_got <= n_got + 1;
        if (tx_last_i) wait_n <= 3;
      end
    end
  end
  // ****************************************
  // Receive side
  // ****************************************
  task automatic rx_frame(input logic [4:0] src, input logic [4:0] dst,
                          input logic xp, input int n, input logic [7:0] b);
    @(posedge core_clk_i);
    rx_sof_o <= 1'b1;
    rx_hdr_o <= {src, dst, xp};
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk_i);
      rx_sof_o <= 1'b0;
      rx_valid_o <= 1'b1;
      rx_data_o <= b + 8'(k);
    end
    @(posedge core_clk_i);
    {rx_sof_o, rx_valid_o, rx_eof_o} <= 3'b001;
    rx_data_o <= ~rx_data_o;
    @(posedge core_clk_i);
    rx_eof_o <= 1'b0;
  endtask
endmodule

// ---- test/tb_nsm_mailbox.sv ----
/* Self-checking bench of the slave mailbox: register port tasks, send and
   receive sequences against the engine model. Assumes package, store and
   checker compiled first. */
`timescale 1ns/1ns
`include "nsm_defines.svh"
module tb_nsm_mailbox;
  import nsm_pkg::*;
  logic core_clk_i, nrst_i, wr_i, rd_i, slow, err, slave_failed_i, bus_run_i;
  logic [9:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, v;
  logic tx_start_o, tx_prio_o, tx_valid_o, tx_last_o, tx_ready_i, tx_done_i, tx_err_i;
  logic rx_sof_i, rx_valid_i, rx_eof_i, irq_o;
  logic [7:0]  tx_data_o, rx_data_i;
  logic [4:0]  own_station_o, pgm_station_o;
  nsm_tx_hdr_t tx_hdr_o;
  nsm_rx_hdr_t rx_hdr_i;
  int          n_fail, checks, n_start;
  nsm_mailbox u_nsm_mailbox (.core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .tx_hdr_o, .tx_start_o, .tx_prio_o, .tx_valid_o, .tx_data_o, .tx_last_o,
    .tx_ready_i, .tx_done_i, .tx_err_i, .rx_sof_i, .rx_hdr_i, .rx_valid_i, .rx_data_i,
    .rx_eof_i, .slave_failed_i, .bus_run_i, .irq_o, .own_station_o, .pgm_station_o);
  nsm_net_model u_nsm_net_model (.core_clk_i, .nrst_i, .slow_i(slow), .err_i(err),
    .tx_start_i(tx_start_o), .tx_hdr_i(tx_hdr_o), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i),
    .tx_done_o(tx_done_i), .tx_err_o(tx_err_i), .rx_sof_o(rx_sof_i), .rx_hdr_o(rx_hdr_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_eof_o(rx_eof_i));
  // ****************************************
  // Port tasks
  // ****************************************
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (tx_start_o) n_start++;
  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] exp);
    rd(a);
    check(v, exp);
  endtask
  // Polls a handshake bit; a run-out bound closes the run
  task automatic wt(input logic [9:0] a, input int b, input logic val);
    for (int i = 0; i < 80; i++) begin
      rd(a);
      if (v[b] === val) return;
    end
    n_fail++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, v[b], val);
    stop_test();
  endtask
  task automatic send(input logic [9:0] base, input logic [4:0] dst,
                      input logic [6:0] len, input logic [7:0] ctl, input logic e);
    int n;
    n = (len > 64) ? 64 : len;
    err <= e;
    wr(base, {16'h0, 1'b0, len, 3'b000, dst});
    for (int k = 0; k < 32; k++) wr(base + 10'(k + 1), {16'h0, 8'(2*k+1), 8'(2*k+2)});
    wr(`NSM_REG_SHS, {24'h0, ctl});
    wt(`NSM_REG_SHS, 7, 1'b0);
    check(v & 32'h81, {31'h0, e});
    check(32'(u_nsm_net_model.hdr), 32'({dst, dst == 5'h00, dst == 5'h1F, 7'(n), ctl[4]}));
    check(u_nsm_net_model.n_got, n);
    for (int j = 0; j < n; j++) check(u_nsm_net_model.got[j], j + 1);
    check(irq_o, e);
    wr(`NSM_REG_STATUS, 32'hF);
    repeat (2) @(posedge core_clk_i);
    #1 check(irq_o, 1'b0);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {nrst_i, wr_i, rd_i, slow, err, slave_failed_i, bus_run_i} = 7'h00;
    addr_i = 10'h000;
    wdata_i = 32'h0;
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rc(`NSM_REG_OWN, 32'h1);
    rc(`NSM_REG_SEND_LOC, 32'h00200);
    rc(`NSM_REG_RECV_LOC, 32'h0020A);
    rc(`NSM_REG_PGM, 32'h1);
    rc(`NSM_REG_RHS, 32'h80);
    rc(10'h3FF, 32'h0);
    wr(`NSM_REG_OWN, 32'h4);
    #1 check(own_station_o, 5'h04);
    wr(`NSM_REG_MASK, 32'h6);
    $display("registers done");
    send(10'h000, 5'h00, 7'h03, 8'h80, 1'b0);
    send(10'h000, 5'h1F, 7'h46, 8'h90, 1'b1);
    slow <= 1'b1;
    wr(`NSM_REG_SEND_LOC, 32'h10010);
    send(10'h108, 5'h07, 7'h05, 8'h80, 1'b0);
    send(10'h108, 5'h02, 7'h00, 8'h80, 1'b0);
    n_start = 0;
    wr(`NSM_REG_SEND_LOC, 32'h00100);
    wr(`NSM_REG_SHS, 32'h80);
    wt(`NSM_REG_SHS, 7, 1'b0);
    check(v & 32'h81, 32'h01);
    check(n_start, 0);
    $display("send done");
    wr(`NSM_REG_STATUS, 32'hF);
    slave_failed_i <= 1'b1;
    bus_run_i <= 1'b1;
    u_nsm_net_model.rx_frame(5'h03, 5'h04, 1'b1, 5, 8'h01);
    wt(`NSM_REG_RHS, 7, 1'b0);
    rc(`NSM_REG_RHS, 32'h07);
    rc(10'h00A, 32'h0503);
    rc(10'h00B, 32'h0102);
    rc(10'h00C, 32'h0304);
    check(irq_o, 1'b1);
    u_nsm_net_model.rx_frame(5'h09, 5'h1F, 1'b0, 2, 8'h40);
    repeat (6) @(posedge core_clk_i);
    rc(10'h00A, 32'h0503);
    rc(`NSM_REG_STATUS, 32'h0C);
    wr(`NSM_REG_STATUS, 32'hF);
    wr(`NSM_REG_RX_AREA, 32'h2);
    wr(`NSM_REG_RHS, 32'h80);
    u_nsm_net_model.rx_frame(5'h00, 5'h1F, 1'b0, 4, 8'h10);
    wt(`NSM_REG_RHS, 7, 1'b0);
    rc(10'h00B, 32'h1011);
    rc(10'h00C, 32'h0304);
    rd(10'h00A);
    check(v & 32'hFF, 32'h00);
    rc(`NSM_REG_STATUS, 32'h04);
    $display("receive done");
    stop_test();
  end
endmodule
